//--- logic/sftfs_fault_word.sv
`timescale 1ns/1ns
`default_nettype none
`include "sftfs_params.svh"
// packs supply and channel faults into the 48-bit word
module sftfs_fault_word
  import sftfs_pkg::*;
(
  input wire logic [`SFTFS_SUP_W-1:0] supFault,
  input wire logic pfcOtpFault,
  input wire logic [`SFTFS_NUM_CH*`SFTFS_CH_FLT_W-1:0] chFault,
  input wire logic [1:0] auxChFault,
  output logic [`SFTFS_FLT_W-1:0] faultWord
);
  // fixed placement, one means active, unused bits zero
  always_comb begin
    faultWord = '0;
    faultWord[`SFTFS_SUP_W-1:0] = supFault;
    faultWord[`SFTFS_PFC_OTP_BIT] = pfcOtpFault;
    faultWord[`SFTFS_CH1_LSB +: `SFTFS_CH_FLT_W] = chFault[0 +: `SFTFS_CH_FLT_W];
    faultWord[`SFTFS_AUX2_BIT] = auxChFault[0];
    faultWord[`SFTFS_CH2_LSB +: `SFTFS_CH_FLT_W] = chFault[`SFTFS_CH_FLT_W +: `SFTFS_CH_FLT_W];
    faultWord[`SFTFS_AUX3_BIT] = auxChFault[1];
    faultWord[`SFTFS_CH3_LSB +: `SFTFS_CH_FLT_W] = chFault[2*`SFTFS_CH_FLT_W +: `SFTFS_CH_FLT_W];
  end
endmodule : sftfs_fault_word
`default_nettype wire

//--- logic/sftfs_selftest_fault_status.sv
`timescale 1ns/1ns
`default_nettype none
`include "sftfs_params.svh"
// status byte clears, self-test results and supply fault word
module sftfs_selftest_fault_status
  import sftfs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic serialPoll, // poll strobe
  input wire logic esrRead, // event status query strobe
  input wire logic errQuery, // error queue query strobe
  input wire logic errQueueEmpty, // queue empty after the read
  input wire logic setSrq, // hardware sets service request
  input wire logic setEsb, // event summary set
  input wire logic setEav, // error available set
  input wire logic [7:0] esrEvents, // event status set bits
  input wire logic unitTestCmd, // unit self-test command
  input wire logic chTestCmd, // channel_self_test_cmd strobe
  input wire logic [1:0] chTestSel, // channel 1..3
  input wire logic [`SFTFS_RES_USED-1:0] testFailRaw, // fault lines from test hardware, async
  input wire logic [`SFTFS_SUP_W-1:0] supFaultRaw, // supply faults, async
  input wire logic pfcOtpRaw,
  input wire logic [`SFTFS_NUM_CH*`SFTFS_CH_FLT_W-1:0] chFaultRaw,
  input wire logic [1:0] auxChRaw,
  output logic [7:0] statusByte,
  output logic [7:0] esrValue,
  output logic [`SFTFS_RES_W-1:0] self_test_result,
  output logic [`SFTFS_RES_W-1:0] chResult1,
  output logic [`SFTFS_RES_W-1:0] chResult2,
  output logic [`SFTFS_RES_W-1:0] chResult3,
  output logic [`SFTFS_FLT_W-1:0] supply_fault_word,
  output logic testBusy,
  output logic faultLed, // lit while hardware fault stored
  output logic panelFault // front panel fault flag
);
  localparam int unsigned TestCyc = `SFTFS_TEST_CYC;
  localparam int RawW = `SFTFS_RES_USED + `SFTFS_SUP_W + 1 + `SFTFS_NUM_CH*`SFTFS_CH_FLT_W + 2;

  // two-stage synchroniser for all async fault inputs
  logic [RawW-1:0] syncA_ff;
  logic [RawW-1:0] syncB_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= {testFailRaw, supFaultRaw, pfcOtpRaw, chFaultRaw, auxChRaw};
      syncB_ff <= syncA_ff;
    end
  end

  // unpack synchronised lines
  logic [`SFTFS_RES_USED-1:0] testFail;
  logic [`SFTFS_SUP_W-1:0] supFault;
  logic pfcOtp;
  logic [`SFTFS_NUM_CH*`SFTFS_CH_FLT_W-1:0] chFault;
  logic [1:0] auxCh;
  assign {testFail, supFault, pfcOtp, chFault, auxCh} = syncB_ff;

  // status byte: set wins over clear
  logic [7:0] stb_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stb_ff <= 8'h00;
    end else begin
      if (setSrq) begin
        stb_ff[`SFTFS_STB_SRQ] <= 1'b1;
      end else if (serialPoll) begin
        stb_ff[`SFTFS_STB_SRQ] <= 1'b0;
      end
      if (setEsb || (|esrEvents)) begin
        stb_ff[`SFTFS_STB_ESB] <= 1'b1;
      end else if (esrRead) begin
        stb_ff[`SFTFS_STB_ESB] <= 1'b0;
      end
      if (setEav) begin
        stb_ff[`SFTFS_STB_EAV] <= 1'b1;
      end else if (errQuery && errQueueEmpty) begin
        stb_ff[`SFTFS_STB_EAV] <= 1'b0;
      end
    end
  end
  assign statusByte = stb_ff;

  // event status register, cleared by its own read
  logic [7:0] esr_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      esr_ff <= 8'h00;
    end else if (esrRead) begin
      esr_ff <= esrEvents; // clear, new events kept
    end else begin
      esr_ff <= esr_ff | esrEvents;
    end
  end
  assign esrValue = esr_ff;

  // self-test sequencer
  sftfs_state_t state_ff;
  sftfs_scope_t scope_ff;
  logic [15:0] cnt_ff;
  logic [`SFTFS_RES_USED-1:0] acc_ff; // accumulated fail bits
  logic pupPend_ff; // power-up test pending
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= SFTFS_IDLE;
      scope_ff <= SFTFS_UNIT;
      cnt_ff <= 16'h0000;
      acc_ff <= '0;
      pupPend_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        SFTFS_IDLE: begin
          cnt_ff <= 16'h0000;
          acc_ff <= '0;
          if (pupPend_ff || unitTestCmd) begin
            state_ff <= SFTFS_RUN;
            scope_ff <= SFTFS_UNIT;
            pupPend_ff <= 1'b0;
          end else if (chTestCmd && chTestSel != 2'b00) begin
            state_ff <= SFTFS_RUN;
            scope_ff <= sftfs_scope_t'(chTestSel);
          end
        end
        SFTFS_RUN: begin
          acc_ff <= acc_ff | testFail; // one means fault
          cnt_ff <= cnt_ff + 16'h0001;
          if (cnt_ff == 16'(TestCyc - 1)) begin
            state_ff <= SFTFS_DONE;
          end
        end
        SFTFS_DONE: begin
          state_ff <= SFTFS_IDLE;
        end
        default: begin
          state_ff <= SFTFS_IDLE;
        end
      endcase
    end
  end

  // result registers, replaced only when a test of that scope ends
  logic [`SFTFS_RES_W-1:0] res_ff [0:`SFTFS_NUM_CH];
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i <= `SFTFS_NUM_CH; i++) begin
        res_ff[i] <= 8'h00;
      end
    end else if (state_ff == SFTFS_DONE) begin
      res_ff[scope_ff] <= {2'b00, acc_ff};
    end
  end
  assign self_test_result = res_ff[0];
  assign chResult1 = res_ff[1];
  assign chResult2 = res_ff[2];
  assign chResult3 = res_ff[3];

  // busy, led and panel flag
  logic busy_ff;
  logic led_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
      led_ff <= 1'b0;
    end else begin
      busy_ff <= (state_ff != SFTFS_IDLE) || pupPend_ff;
      led_ff <= res_ff[0][0] | res_ff[1][0] | res_ff[2][0] | res_ff[3][0];
    end
  end
  assign testBusy = busy_ff;
  assign faultLed = led_ff;
  assign panelFault = led_ff;

  // fault word, registered
  logic [`SFTFS_FLT_W-1:0] wordNext;
  logic [`SFTFS_FLT_W-1:0] word_ff;
  sftfs_fault_word uPack (
    .supFault(supFault),
    .pfcOtpFault(pfcOtp),
    .chFault(chFault),
    .auxChFault(auxCh),
    .faultWord(wordNext)
  );
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      word_ff <= '0;
    end else begin
      word_ff <= wordNext;
    end
  end
  assign supply_fault_word = word_ff;

  // run length as a plain int for the delay checks
  localparam int RunLen = `SFTFS_TEST_CYC;

  // checks: status byte
  // poll drops the request bit unless a new request lands
  AST_SRQ_CLR: assert property (@(posedge clk_sys) disable iff (!arst_n)
    serialPoll && !setSrq |=> !statusByte[`SFTFS_STB_SRQ])
    else $error("service request not cleared by poll");
  // a new request wins over a poll in the same cycle
  AST_SRQ_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
    setSrq |=> statusByte[`SFTFS_STB_SRQ])
    else $error("service request lost");
  // poll leaves every other bit alone
  AST_POLL_KEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    serialPoll && !setEsb && !(|esrEvents) && !esrRead && !errQuery && !setEav
    |=> statusByte[`SFTFS_STB_ESB:0] == $past(statusByte[`SFTFS_STB_ESB:0]))
    else $error("poll changed status byte");
  // event read empties the register and the summary bit
  AST_ESR_CLR: assert property (@(posedge clk_sys) disable iff (!arst_n)
    esrRead && esrEvents == 8'h00 && !setEsb
    |=> esrValue == 8'h00 && !statusByte[`SFTFS_STB_ESB])
    else $error("event status not cleared by read");
  // without a read, latched events stay latched
  AST_ESR_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !esrRead |=> (esrValue & $past(esrValue)) == $past(esrValue))
    else $error("event status lost without read");
  // a query that leaves items queued keeps the available bit
  AST_EAV_KEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    errQuery && !errQueueEmpty && statusByte[`SFTFS_STB_EAV] |=> statusByte[`SFTFS_STB_EAV])
    else $error("error available bit lost");
  // a query that empties the queue drops the available bit
  AST_EAV_CLR: assert property (@(posedge clk_sys) disable iff (!arst_n)
    errQuery && errQueueEmpty && !setEav |=> !statusByte[`SFTFS_STB_EAV])
    else $error("error available bit kept");

  // checks: self-test sequencing
  sequence sRunStart;
    state_ff == SFTFS_IDLE ##1 state_ff == SFTFS_RUN;
  endsequence
  sequence sTestEnd;
    state_ff == SFTFS_RUN ##1 state_ff == SFTFS_DONE;
  endsequence
  // pending power-up test goes first and covers the unit
  AST_PWRUP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pupPend_ff && state_ff == SFTFS_IDLE |=> state_ff == SFTFS_RUN && scope_ff == SFTFS_UNIT)
    else $error("power-up test not started");
  // unit command from idle starts a unit test
  AST_UNIT_CMD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_ff == SFTFS_IDLE && unitTestCmd |=> state_ff == SFTFS_RUN && scope_ff == SFTFS_UNIT)
    else $error("unit test not started");
  // channel command from idle starts a test of that channel
  AST_CH_CMD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_ff == SFTFS_IDLE && !pupPend_ff && !unitTestCmd && chTestCmd && chTestSel != 2'b00
    |=> state_ff == SFTFS_RUN && scope_ff == $past(chTestSel))
    else $error("channel test not started");
  // channel zero selects nothing and is ignored
  AST_CH_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_ff == SFTFS_IDLE && !pupPend_ff && !unitTestCmd && chTestCmd && chTestSel == 2'b00
    |=> state_ff == SFTFS_IDLE)
    else $error("channel zero started a test");
  // a run lasts the fixed test time, then ends
  AST_RUN_LEN: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sRunStart |-> ##RunLen state_ff == SFTFS_DONE)
    else $error("test run length wrong");
  // busy shows while the sequencer is away from idle
  AST_BUSY: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_ff != SFTFS_IDLE |=> testBusy)
    else $error("busy low during test");

  // checks: stored results and fault indication
  // unused result bits never set, in any scope
  AST_RESULT_RANGE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    self_test_result[7:6] == 2'b00 && chResult1[7:6] == 2'b00
    && chResult2[7:6] == 2'b00 && chResult3[7:6] == 2'b00)
    else $error("unused result bits set");
  // end of a run stores the gathered fail bits
  AST_RESULT_LOAD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sTestEnd |=> res_ff[scope_ff] == {2'b00, $past(acc_ff)})
    else $error("result not stored");
  // unit result moves only when a unit run ends
  AST_RESULT_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(state_ff == SFTFS_DONE && scope_ff == SFTFS_UNIT)
    |=> self_test_result == $past(self_test_result))
    else $error("unit result changed");
  // channel results move only when a channel run ends
  AST_CH_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_ff != SFTFS_DONE || scope_ff == SFTFS_UNIT
    |=> chResult1 == $past(chResult1) && chResult2 == $past(chResult2) && chResult3 == $past(chResult3))
    else $error("channel result changed");
  // stored hardware fault lights led and panel flag
  AST_LED: assert property (@(posedge clk_sys) disable iff (!arst_n)
    self_test_result[0] |=> faultLed && panelFault)
    else $error("fault led not lit");
  // led dark while no stored hardware fault
  AST_LED_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(self_test_result[0] || chResult1[0] || chResult2[0] || chResult3[0])
    |=> !faultLed && !panelFault)
    else $error("fault led lit without fault");

  // checks: fault word
  // unused positions always read zero
  AST_UNUSED_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
    supply_fault_word[19:14] == 6'h00 && supply_fault_word[35:29] == 7'h00
    && supply_fault_word[47:45] == 3'h0)
    else $error("unused fault bits set");
  // supply-wide bits follow their synchronised lines
  AST_WORD_SUP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    1'b1 |=> supply_fault_word[`SFTFS_SUP_W-1:0] == $past(supFault)
    && supply_fault_word[`SFTFS_PFC_OTP_BIT] == $past(pfcOtp))
    else $error("supply fault bits misplaced");
  // channel one bits sit right above the five supply bits, below the pfc bit
  AST_WORD_CH1: assert property (@(posedge clk_sys) disable iff (!arst_n)
    1'b1 |=> supply_fault_word[`SFTFS_CH1_LSB +: `SFTFS_CH_FLT_W] == $past(chFault[`SFTFS_CH_FLT_W-1:0]))
    else $error("channel one fault bits misplaced");
  // a quiet set of lines gives a clean word
  AST_WORD_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(|supFault) && !pfcOtp && !(|chFault) && !(|auxCh)
    |=> supply_fault_word == '0)
    else $error("fault word not clean");
endmodule : sftfs_selftest_fault_status
`default_nettype wire

//--- shared/sftfs_params.svh
`ifndef SFTFS_PARAMS_SVH
`define SFTFS_PARAMS_SVH
`define SFTFS_STB_SRQ 6
`define SFTFS_STB_ESB 5
`define SFTFS_STB_EAV 2
`define SFTFS_RES_W 8
`define SFTFS_RES_USED 6
`define SFTFS_FLT_W 48
`define SFTFS_CH_FLT_W 8
`define SFTFS_SUP_W 5
`define SFTFS_CH1_LSB 5
`define SFTFS_PFC_OTP_BIT 13
`define SFTFS_AUX2_BIT 20
`define SFTFS_CH2_LSB 21
`define SFTFS_AUX3_BIT 36
`define SFTFS_CH3_LSB 37
`define SFTFS_NUM_CH 3
`define SFTFS_TEST_TIME_NS 400
`define SFTFS_CLK_NS 4
`define SFTFS_TEST_CYC ((`SFTFS_TEST_TIME_NS + `SFTFS_CLK_NS - 1) / `SFTFS_CLK_NS)
`endif

//--- shared/sftfs_pkg.sv
package sftfs_pkg;
  // self-test sequencer states
  typedef enum logic [1:0] {
    SFTFS_IDLE = 2'b00,
    SFTFS_RUN = 2'b01,
    SFTFS_DONE = 2'b10
  } sftfs_state_t;
  // which scope a test covers
  typedef enum logic [1:0] {
    SFTFS_UNIT = 2'b00,
    SFTFS_CH1 = 2'b01,
    SFTFS_CH2 = 2'b10,
    SFTFS_CH3 = 2'b11
  } sftfs_scope_t;
endpackage : sftfs_pkg

//--- sim/sftfs_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// remote controller: one-cycle poll, query and test strobes
module sftfs_ctrl_model (
  input wire logic clk_sys,
  output wire logic serialPoll,
  output wire logic esrRead,
  output wire logic errQuery,
  output wire logic unitTestCmd,
  output wire logic chTestCmd,
  output logic [1:0] chTestSel
);
  logic [4:0] req = 5'h00; // one bit a request kind
  // kinds: 0 poll, 1 event read, 2 error query, 3 unit test, 4 channel test
  assign {chTestCmd, unitTestCmd, errQuery, esrRead, serialPoll} = req;
  initial chTestSel = 2'h0;
  // raise after an edge, hold through one sampling edge, then drop
  task automatic issue(input int kind, input logic [1:0] sel);
    @(posedge clk_sys);
    #1;
    chTestSel = sel;
    req = 5'h01 << kind;
    @(posedge clk_sys);
    #1;
    req = 5'h00;
  endtask : issue
endmodule : sftfs_ctrl_model
`default_nettype wire

//--- sim/sftfs_selftest_fault_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "sftfs_params.svh"
// bench: status clears, self-test results, fault word
module sftfs_selftest_fault_status_tb;
  logic clk_sys = 1'b0; // 4 ns clock
  logic arst_n = 1'b0; // held low at start
  logic setSrq = 1'b0, setEsb = 1'b0, setEav = 1'b0; // status set pulses
  logic errQueueEmpty = 1'b0; // queue state at query
  logic [7:0] esrEvents = 8'h00; // event set bits
  logic [5:0] testFailRaw = 6'h1f; // power-up test sees faults
  logic [31:0] raw = 32'h0; // aux, channel, pfc, supply fault lines
  wire logic serialPoll, esrRead, errQuery, unitTestCmd, chTestCmd;
  wire logic [1:0] chTestSel;
  logic [7:0] statusByte, esrValue, stRes, chRes1, chRes2, chRes3;
  logic [47:0] faultWord;
  logic testBusy, faultLed, panelFault;
  logic [7:0] expCh [1:3] = '{default: 8'h00}; // stored channel results
  int n_errors = 0;
  int n_compared = 0;
  always #2 clk_sys = ~clk_sys;
  sftfs_ctrl_model ctrl (.clk_sys(clk_sys), .serialPoll(serialPoll), .esrRead(esrRead),
    .errQuery(errQuery), .unitTestCmd(unitTestCmd), .chTestCmd(chTestCmd), .chTestSel(chTestSel));
  sftfs_selftest_fault_status dut (.clk_sys(clk_sys), .arst_n(arst_n), .serialPoll(serialPoll),
    .esrRead(esrRead), .errQuery(errQuery), .errQueueEmpty(errQueueEmpty), .setSrq(setSrq),
    .setEsb(setEsb), .setEav(setEav), .esrEvents(esrEvents), .unitTestCmd(unitTestCmd),
    .chTestCmd(chTestCmd), .chTestSel(chTestSel), .testFailRaw(testFailRaw),
    .supFaultRaw(raw[4:0]), .pfcOtpRaw(raw[5]), .chFaultRaw(raw[29:6]), .auxChRaw(raw[31:30]),
    .statusByte(statusByte), .esrValue(esrValue), .self_test_result(stRes), .chResult1(chRes1),
    .chResult2(chRes2), .chResult3(chRes3), .supply_fault_word(faultWord), .testBusy(testBusy),
    .faultLed(faultLed), .panelFault(panelFault));
  // compare and count
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // step n edges, land just after the last
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle
  // one-cycle pulse on the status set inputs
  task automatic set_bits(input logic [2:0] s, input logic [7:0] ev);
    settle(1);
    {setSrq, setEsb, setEav} = s;
    esrEvents = ev;
    settle(1);
    {setSrq, setEsb, setEav} = 3'h0;
    esrEvents = 8'h00;
    settle(1);
  endtask : set_bits
  // bounded wait for a test to start and finish
  task automatic wait_done;
    int i;
    i = 0;
    while (testBusy !== 1'b1 && i < 10) begin
      settle(1);
      i++;
    end
    chk("testBusy", 48'h1, testBusy);
    while (testBusy !== 1'b0 && i < 300) begin
      settle(1);
      i++;
    end
    chk("testBusy", 48'h0, testBusy);
    settle(2);
  endtask : wait_done
  // raw line index to fault word position
  function automatic int bit_pos(input int k);
    if (k < 5) return k;
    if (k == 5) return 13;
    if (k < 14) return k - 1;
    if (k < 22) return k + 7;
    if (k < 30) return k + 15;
    return (k == 30) ? 20 : 36;
  endfunction : bit_pos
  // counts, verdict, end
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // watchdog, far beyond the expected run
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    $display("wrong value watchdog expected done seen timeout");
    close_out();
  end
  // main sequence
  initial begin
    settle(20);
    arst_n = 1'b1;
    wait_done();
    chk("self_test_result", 48'h1f, stRes);
    chk("faultLed", 48'h1, faultLed);
    chk("panelFault", 48'h1, panelFault);
    $display("test power_up done");
    testFailRaw = 6'h00;
    ctrl.issue(3, 2'h0);
    wait_done();
    chk("self_test_result", 48'h0, stRes);
    chk("faultLed", 48'h0, faultLed);
    chk("panelFault", 48'h0, panelFault);
    $display("test unit_pass done");
    for (int c = 1; c <= 3; c++) begin
      testFailRaw = 6'(c * 11);
      expCh[c] = 8'(c * 11);
      ctrl.issue(4, 2'(c));
      wait_done();
      chk("chResult1", {40'h0, expCh[1]}, chRes1);
      chk("chResult2", {40'h0, expCh[2]}, chRes2);
      chk("chResult3", {40'h0, expCh[3]}, chRes3);
      chk("self_test_result", 48'h0, stRes);
    end
    chk("faultLed", 48'h1, faultLed);
    ctrl.issue(4, 2'h0);
    settle(3);
    chk("testBusy", 48'h0, testBusy);
    $display("test channels done");
    testFailRaw = 6'h21;
    settle(1);
    arst_n = 1'b0;
    settle(3);
    chk("chResult1", 48'h0, chRes1);
    chk("faultLed", 48'h0, faultLed);
    arst_n = 1'b1;
    wait_done();
    chk("self_test_result", 48'h21, stRes);
    chk("chResult3", 48'h0, chRes3);
    chk("faultLed", 48'h1, faultLed);
    $display("test power_cycle done");
    set_bits(3'h7, 8'h00);
    chk("statusByte", 48'h64, statusByte);
    ctrl.issue(0, 2'h0);
    settle(1);
    chk("statusByte", 48'h24, statusByte);
    set_bits(3'h0, 8'h10);
    chk("esrValue", 48'h10, esrValue);
    chk("statusByte", 48'h24, statusByte);
    ctrl.issue(1, 2'h0);
    settle(1);
    chk("statusByte", 48'h04, statusByte);
    chk("esrValue", 48'h0, esrValue);
    ctrl.issue(2, 2'h0);
    settle(1);
    chk("statusByte", 48'h04, statusByte);
    errQueueEmpty = 1'b1;
    ctrl.issue(2, 2'h0);
    settle(1);
    chk("statusByte", 48'h00, statusByte);
    $display("test status done");
    for (int k = 0; k < 32; k++) begin
      raw = 32'h1 << k;
      settle(4);
      chk("supply_fault_word", 48'h1 << bit_pos(k), faultWord);
    end
    raw = 32'hffffffff;
    settle(4);
    chk("supply_fault_word", 48'h1ff01ff03fff, faultWord);
    raw = 32'h0;
    settle(4);
    chk("supply_fault_word", 48'h0, faultWord);
    $display("test fault_word done");
    close_out();
  end
endmodule : sftfs_selftest_fault_status_tb
`default_nettype wire
